// [pbsc_pkg.sv]
// pbsc_pkg: constants and types for the power button state controller
// assumes a 10 MHz clock; all times are converted to cycle counts here
package pbsc_pkg;
  localparam int unsigned ClockHz     = 10000000;
  localparam int unsigned Time0Ms     = 0;
  localparam int unsigned Time50Ms    = 50;
  localparam int unsigned Time100Ms   = 100;
  localparam int unsigned Time500Ms   = 500;
  localparam int unsigned Timeout5S   = 5;
  localparam int unsigned Timeout10S  = 10;
  localparam int unsigned Timeout15S  = 15;
  localparam int unsigned CyclesPerMs = ClockHz / 1000;
  localparam int unsigned Cyc50Ms     = Time50Ms * CyclesPerMs;
  localparam int unsigned Cyc100Ms    = Time100Ms * CyclesPerMs;
  localparam int unsigned Cyc500Ms    = Time500Ms * CyclesPerMs;
  localparam int unsigned Cyc5S       = Timeout5S * ClockHz;
  localparam int unsigned Cyc10S      = Timeout10S * ClockHz;
  localparam int unsigned Cyc15S      = Timeout15S * ClockHz;
  localparam int unsigned CountWidth  = 28;
  localparam logic [1:0]  Sel0        = 2'h0;
  localparam logic [1:0]  Sel50       = 2'h1;
  localparam logic [1:0]  Sel100      = 2'h2;
  localparam logic [1:0]  Sel500      = 2'h3;
  localparam logic [1:0]  TmoOff      = 2'h3;
  localparam logic [1:0]  ResetState  = 2'h0;

  typedef enum logic [1:0] {
    PBSC_OFF,
    PBSC_ON,
    PBSC_RAILRST
  } pbsc_state_type;
endpackage : pbsc_pkg

// [pbsc_sync_if.sv]
// pbsc_sync_if: synchronised button levels between top and synchroniser
// assumes one clock domain shared by both ends
`timescale 1ns/1ns
interface pbsc_sync_if;
  logic powerButton;
  logic resetButton;
  modport source (output powerButton, output resetButton);
  modport sink   (input powerButton, input resetButton);
endinterface : pbsc_sync_if

// [pbsc_input_sync.sv]
// pbsc_input_sync: two-flop synchronisers for the two buttons
// assumes button pins are asynchronous mechanical levels, active high
`timescale 1ns/1ns
module pbsc_input_sync (
  input  wire logic   clock,
  input  wire logic   srst,
  input  wire logic   powerButtonPin,
  input  wire logic   resetButtonPin,
  pbsc_sync_if.source syncOut
);
  logic [1:0] firstStage;
  logic [1:0] secondStage;

  always_ff @(posedge clock) begin
    if (srst) begin
      firstStage  <= 2'h0;
      secondStage <= 2'h0;
    end else begin
      firstStage  <= {resetButtonPin, powerButtonPin};
      secondStage <= firstStage;
    end
  end

  assign syncOut.powerButton = secondStage[0];
  assign syncOut.resetButton = secondStage[1];
endmodule : pbsc_input_sync

// [pbsc_controller.sv]
// pbsc_controller: power button state controller top
// assumes a 10 MHz always-on clock and synchronous active-high reset
//
// What this block does
// - button presses produce power-on and power-down requests toward the power management unit
// - debounce and off-to-on times each select 0, 50, 100 or 500 ms
// - in ON, holding past debounce time raises the power-off interrupt
// - in OFF, holding past off-to-on time requests power-on and enters ON
// - maximum timeout selects 5 s, 10 s, 15 s or disabled
// - held for the enabled maximum timeout with the reset button released, power-down is requested
// - reset button in ON forces rails into reset except always-on supply
// - reset button switches processor off at once, boot restarts from OFF
`timescale 1ns/1ns
module pbsc_controller
  import pbsc_pkg::*;
#(
  parameter int unsigned DebCyc50   = pbsc_pkg::Cyc50Ms,
  parameter int unsigned DebCyc100  = pbsc_pkg::Cyc100Ms,
  parameter int unsigned DebCyc500  = pbsc_pkg::Cyc500Ms,
  parameter int unsigned TmoCyc5    = pbsc_pkg::Cyc5S,
  parameter int unsigned TmoCyc10   = pbsc_pkg::Cyc10S,
  parameter int unsigned TmoCyc15   = pbsc_pkg::Cyc15S
) (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       powerButtonPin,
  input  wire logic       resetButtonPin,
  input  wire logic [1:0] debounceSel,
  input  wire logic [1:0] offToOnSel,
  input  wire logic [1:0] maxTimeoutSel,
  output logic            powerOffIrq,
  output logic            powerOnRequest,
  output logic            powerDownRequest,
  output logic            railsInReset,
  output logic            processorOn,
  output logic            systemOn
);
  import pbsc_pkg::*;

  localparam int W = pbsc_pkg::CountWidth;

  pbsc_sync_if syncBus ();

  pbsc_input_sync u_sync (
    .clock          (clock),
    .srst           (srst),
    .powerButtonPin (powerButtonPin),
    .resetButtonPin (resetButtonPin),
    .syncOut        (syncBus.source)
  );

  wire logic buttonHeld = syncBus.powerButton;
  wire logic resetHeld  = syncBus.resetButton;

  pbsc_state_type state;
  pbsc_state_type next_state;
  logic [W-1:0]   holdCount;
  logic           irqDone;
  logic           downDone;

  // threshold decoding; a 0 ms choice fires on the second held cycle, once the count is 1
  function automatic logic [W-1:0] shortSel(input logic [1:0] sel);
    logic [W-1:0] r;
    r = '0;
    unique case (sel)
      Sel0:   r = '0;
      Sel50:  r = W'(DebCyc50);
      Sel100: r = W'(DebCyc100);
      Sel500: r = W'(DebCyc500);
    endcase
    return r;
  endfunction : shortSel

  wire logic [W-1:0] debounceLimit = shortSel(debounceSel);
  wire logic [W-1:0] offToOnLimit  = shortSel(offToOnSel);
  wire logic [W-1:0] timeoutLimit  =
    (maxTimeoutSel == 2'h0) ? W'(TmoCyc5)  :
    (maxTimeoutSel == 2'h1) ? W'(TmoCyc10) : W'(TmoCyc15);
  wire logic timeoutEnabled = (maxTimeoutSel != TmoOff);

  // "held longer than" means the count strictly exceeds the limit
  wire logic pastDebounce = buttonHeld && (holdCount > debounceLimit);
  wire logic pastOffToOn  = buttonHeld && (holdCount > offToOnLimit);
  wire logic reachTimeout = buttonHeld && timeoutEnabled &&
                            (holdCount >= timeoutLimit);
  wire logic fireIrq      = (state == PBSC_ON) && pastDebounce && !irqDone;
  wire logic fireDown     = (state == PBSC_ON) && reachTimeout && !downDone;
  wire logic fireOn       = (state == PBSC_OFF) && pastOffToOn;
  wire logic fireRailRst  = (state == PBSC_ON) && resetHeld;

  always_comb begin
    next_state = state;
    unique case (state)
      PBSC_OFF:     if (fireOn) next_state = PBSC_ON;
      PBSC_ON: begin
        if (fireRailRst) next_state = PBSC_RAILRST;
        else if (fireDown) next_state = PBSC_OFF;
      end
      PBSC_RAILRST: if (!resetHeld) next_state = PBSC_OFF;
      default:      next_state = PBSC_OFF;
    endcase
  end

  // counter saturates so a stuck button cannot wrap and refire
  always_ff @(posedge clock) begin
    if (srst || !buttonHeld || next_state != state) holdCount <= '0;
    else if (holdCount != '1) holdCount <= holdCount + 1'b1;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state    <= PBSC_OFF;
      irqDone  <= 1'b0;
      downDone <= 1'b0;
    end else begin
      state    <= next_state;
      irqDone  <= buttonHeld && (irqDone || fireIrq);    // one interrupt per press
      downDone <= buttonHeld && (downDone || fireDown);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      powerOffIrq      <= 1'b0;
      powerOnRequest   <= 1'b0;
      powerDownRequest <= 1'b0;
      railsInReset     <= 1'b0;
      processorOn      <= 1'b0;
      systemOn         <= 1'b0;
    end else begin
      powerOffIrq      <= fireIrq;
      powerOnRequest   <= fireOn;
      powerDownRequest <= fireDown && !fireRailRst;
      railsInReset     <= (next_state == PBSC_RAILRST);
      processorOn      <= (next_state == PBSC_ON);
      systemOn         <= (next_state == PBSC_ON);
    end
  end

  property p_irq_after_debounce;
    @(posedge clock) disable iff (srst)
      fireIrq |=> powerOffIrq;
  endproperty
  a_irq_after_debounce: assert property (p_irq_after_debounce) else $error("interrupt missing");

  property p_irq_only_on;
    @(posedge clock) disable iff (srst)
      powerOffIrq |-> $past(state) == PBSC_ON && $past(buttonHeld);
  endproperty
  a_irq_only_on: assert property (p_irq_only_on) else $error("interrupt outside ON");

  property p_on_request;
    @(posedge clock) disable iff (srst)
      powerOnRequest |-> processorOn && $past(holdCount) > $past(offToOnLimit);
  endproperty
  a_on_request: assert property (p_on_request) else $error("early power-on");

  property p_zero_sel;
    @(posedge clock) disable iff (srst)
      state == PBSC_OFF && offToOnSel == Sel0 && holdCount == W'(1) && buttonHeld |=> powerOnRequest;
  endproperty
  a_zero_sel: assert property (p_zero_sel) else $error("0 ms select late");

  property p_down_disabled;
    @(posedge clock) disable iff (srst)
      $past(maxTimeoutSel) == TmoOff |-> !powerDownRequest;
  endproperty
  a_down_disabled: assert property (p_down_disabled) else $error("down while disabled");

  property p_down_goes_off;
    @(posedge clock) disable iff (srst)
      powerDownRequest |-> state == PBSC_OFF && !systemOn;
  endproperty
  a_down_goes_off: assert property (p_down_goes_off) else $error("down without off");

  property p_rail_reset;
    @(posedge clock) disable iff (srst)
      state == PBSC_ON && resetHeld |=> railsInReset && !processorOn ##1 state != PBSC_ON;
  endproperty
  a_rail_reset: assert property (p_rail_reset) else $error("rails not reset");

  property p_boot_from_off;
    @(posedge clock) disable iff (srst)
      state == PBSC_RAILRST && !resetHeld |=> state == PBSC_OFF && !railsInReset;
  endproperty
  a_boot_from_off: assert property (p_boot_from_off) else $error("no restart from off");

  property p_count_clears;
    @(posedge clock) disable iff (srst)
      !buttonHeld |=> holdCount == '0;
  endproperty
  a_count_clears: assert property (p_count_clears) else $error("count kept");
endmodule : pbsc_controller

// [pbsc_button_model.sv]
// pbsc_button_model: behavioural power and reset push-buttons
// assumes the bench calls set_pins from the controller clock domain
`timescale 1ns/1ns
module pbsc_button_model (
  input  wire logic clock,
  output logic      powerPin,
  output logic      resetPin
);
  initial begin
    powerPin = 1'b0;
    resetPin = 1'b0;
  end
  // contacts change just after an edge; bounce is not modelled, glitches come from the bench
  task automatic set_pins(input logic pwr, input logic rst);
    @(posedge clock);
    #1;
    powerPin = pwr;
    resetPin = rst;
  endtask : set_pins
endmodule : pbsc_button_model

// [pbsc_controller_tb_top.sv]
// pbsc_controller_tb_top: self-checking bench for the power button controller
// assumes shortened hold counts and the button model in front of the pins
`timescale 1ns/1ns
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin errorCnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pbsc_controller_tb_top;
  import pbsc_pkg::*;
  // shortened hold counts keep the run short; tables below follow them
  localparam int Deb50  = 5;
  localparam int Deb100 = 10;
  localparam int Deb500 = 20;
  localparam int Tmo5   = 100;
  localparam int Tmo10  = 200;
  localparam int Tmo15  = 300;
  localparam int DebTab [4] = '{0, Deb50, Deb100, Deb500};
  localparam int TmoTab [3] = '{Tmo5, Tmo10, Tmo15};
  logic       clock         = 1'b0;
  logic       srst          = 1'b1;
  logic [1:0] debounceSel   = Sel500;
  logic [1:0] offToOnSel    = Sel0;
  logic [1:0] maxTimeoutSel = TmoOff;
  logic       powerOffIrq, powerOnRequest, powerDownRequest;
  logic       railsInReset, processorOn, systemOn, pwrPin, rstPin;
  int         errorCnt      = 0;
  int         nChecks       = 0;
  int         n;
  always #50 clock = ~clock;
  pbsc_button_model btn (.clock(clock), .powerPin(pwrPin), .resetPin(rstPin));
  pbsc_controller #(.DebCyc50(Deb50), .DebCyc100(Deb100), .DebCyc500(Deb500),
    .TmoCyc5(Tmo5), .TmoCyc10(Tmo10), .TmoCyc15(Tmo15)) dut (
    .clock(clock), .srst(srst), .powerButtonPin(pwrPin), .resetButtonPin(rstPin),
    .debounceSel(debounceSel), .offToOnSel(offToOnSel), .maxTimeoutSel(maxTimeoutSel),
    .powerOffIrq(powerOffIrq), .powerOnRequest(powerOnRequest), .powerDownRequest(powerDownRequest),
    .railsInReset(railsInReset), .processorOn(processorOn), .systemOn(systemOn));
  // which: 0 power-on request, 1 irq, 2 power-down; returns edges waited
  task automatic wait_out(input int which, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (hit !== 1'b1 && cnt < lim) begin
      @(posedge clock);
      #1;
      cnt++;
      hit = (which == 0) ? powerOnRequest : (which == 1) ? powerOffIrq : powerDownRequest;
    end
  endtask : wait_out
  task automatic do_reset();
    btn.set_pins(1'b0, 1'b0);
    srst = 1'b1;
    repeat (12) @(posedge clock);
    #1 srst = 1'b0;
    `CHK({powerOnRequest, powerOffIrq, powerDownRequest, railsInReset, processorOn, systemOn}, 6'h00)
  endtask : do_reset
  task automatic power_on(input logic [1:0] sel);
    do_reset();
    offToOnSel = sel;
    btn.set_pins(1'b1, 1'b0);
    wait_out(0, 60, n);
    // two sync edges, limit+1 counted cycles, then the registered request
    `CHK(n, DebTab[sel] + 4)
    `CHK({processorOn, systemOn}, 2'h3)
    btn.set_pins(1'b0, 1'b0);
    repeat (8) @(posedge clock);
    #1;
  endtask : power_on
  task automatic test_on_times();
    for (int s = 0; s < 4; s++) power_on(s[1:0]);
    $display("done: off-to-on times");
  endtask : test_on_times
  task automatic test_irq();
    power_on(Sel0);
    for (int s = 0; s < 4; s++) begin
      debounceSel = s[1:0];
      btn.set_pins(1'b1, 1'b0);
      wait_out(1, 60, n);
      `CHK(n, DebTab[s] + 4)
      wait_out(1, 30, n);
      `CHK(n, 30)
      btn.set_pins(1'b0, 1'b0);
      repeat (5) @(posedge clock);
      #1;
    end
    $display("done: power-off interrupt");
  endtask : test_irq
  task automatic test_timeout();
    for (int t = 0; t < 4; t++) begin
      power_on(Sel0);
      maxTimeoutSel = t[1:0];
      btn.set_pins(1'b1, 1'b0);
      wait_out(2, 400, n);
      // the disabled code must hold on for the whole window
      if (t == 3) `CHK({n[15:0], processorOn}, {16'd400, 1'b1})
      else `CHK(n, TmoTab[t] + 3)
      // a still-held button with a 0 ms off-to-on time powers up again soon after
      `CHK(processorOn, (t == 3))
      repeat (2) @(posedge clock);
      btn.set_pins(1'b0, 1'b0);
    end
    $display("done: max timeout");
  endtask : test_timeout
  task automatic test_reset_button();
    power_on(Sel0);
    btn.set_pins(1'b0, 1'b1);
    repeat (4) @(posedge clock);
    `CHK({railsInReset, processorOn}, 2'h2)
    btn.set_pins(1'b0, 1'b0);
    repeat (4) @(posedge clock);
    `CHK({railsInReset, systemOn}, 2'h0)
    btn.set_pins(1'b0, 1'b1);
    repeat (4) @(posedge clock);
    `CHK(railsInReset, 1'b0)
    btn.set_pins(1'b0, 1'b0);
    $display("done: reset button");
  endtask : test_reset_button
  task automatic test_glitch();
    do_reset();
    offToOnSel = Sel50;
    // two short presses add up past the limit; only a continuous hold may count
    repeat (2) begin
      btn.set_pins(1'b1, 1'b0);
      repeat (3) @(posedge clock);
      btn.set_pins(1'b0, 1'b0);
    end
    repeat (10) @(posedge clock);
    `CHK(processorOn, 1'b0)
    $display("done: broken presses");
  endtask : test_glitch
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  initial begin
    test_on_times();
    test_irq();
    test_timeout();
    test_reset_button();
    test_glitch();
    conclude();
  end
  // about 1600 cycles expected; cut at 10000
  initial begin
    #1000000;
    errorCnt++;
    conclude();
  end
endmodule : pbsc_controller_tb_top
